// ===== src/sflash_defines.svh
// Command codes, status layout, reset values and timing counts of the flash command block
`ifndef SFLASH_DEFINES_SVH
`define SFLASH_DEFINES_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_WRITE_ARM      8'h06
`define CMD_WRITE_DISARM   8'h04
`define CMD_STATUS_READ    8'h05
`define CMD_STATUS_WRITE   8'h01
`define CMD_ARRAY_READ     8'h03
`define CMD_PAGE_WRITE     8'h02
`define CMD_REGION_WIPE    8'hd8
`define CMD_FULL_WIPE      8'hc7

// ****************************************************************
// Status register layout
// ****************************************************************
`define SR_BUSY_BIT        0
`define SR_ARM_BIT         1
`define SR_BP_LSB          2
`define SR_BP_MSB          4
`define SR_LOCK_BIT        7
`define SR_BP_RESET        3'h0
`define SR_LOCK_RESET      1'h0

// ****************************************************************
// Frame byte counts and sector count
// ****************************************************************
`define ADDR_LAST_BYTE     3'h3
`define PAGE_DATA_BYTE     3'h4
`define BYTE_CNT_MAX       3'h7
`define SECTOR_COUNT       5'h10

// ****************************************************************
// Timing
// ****************************************************************
`define MCLK_PERIOD_NS     10
`define T_STATUS_WRITE_NS  10000
`define T_PAGE_WRITE_NS    100000
`define T_REGION_WIPE_NS   200000
`define T_FULL_WIPE_NS     400000
`define STATUS_WRITE_CYCLES ((`T_STATUS_WRITE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define PAGE_WRITE_CYCLES   ((`T_PAGE_WRITE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define REGION_WIPE_CYCLES  ((`T_REGION_WIPE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define FULL_WIPE_CYCLES    ((`T_FULL_WIPE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// ===== src/sflash_pkg.sv
// Types shared by the flash command block and its bench
package sflash_pkg;

    typedef enum logic [2:0] {
        FR_NONE,
        FR_ARM,
        FR_DISARM,
        FR_STATUS_WRITE,
        FR_PAGE_WRITE,
        FR_REGION_WIPE,
        FR_FULL_WIPE
    } frame_kind_t;

    typedef enum logic {
        CYC_IDLE,
        CYC_RUN
    } cyc_state_t;

    typedef struct packed {
        logic        valid;
        frame_kind_t kind;
        logic [23:0] addr;
    } array_op_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic [7:0]  data;
    } fill_t;

endpackage

// ===== src/sync2.sv
// Two-flop level synchroniser of parameterised width
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_r <= RESET_VAL;
            o_q    <= RESET_VAL;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ===== src/sflash_status_protect_read.sv
// Serial flash command block: status write, protection modes and array read
//
// Functional notes
// - Status write accepted only while the write-arm latch is set.
// - Status write data never loads status bits 6, 5, 1 and 0.
// - Status bits 6 and 5 always read zero.
// - Status write discarded unless select rises right after sixteen bits.
// - Valid status write starts a fixed self-timed cycle at select rise.
// - Status stays readable during the cycle; busy flag one then zero.
// - Write-arm latch clears when the status write cycle completes.
// - Status write loads the three block-protect bits and the lock bit.
// - Status writes refused while hardware locked mode is active.
// - Lock bit zero: status write allowed when armed, any pin level.
// - Lock bit one, protect pin high: status write allowed when armed.
// - Lock bit one, protect pin low: status write rejected even armed.
// - Hardware lock whenever lock bit set and pin low, either order.
// - Hardware lock left by pin going high, or by a status write cycle begun before the pin fell clearing the lock bit.
// - Array read: command then three address bytes, sampled on rising clock.
// - Read data shifted out, changing on falling serial clock edges.
// - Read address increments per byte and wraps from top to zero.
// - Select high ends a read at any bit, immediately.
// - Array read during a busy cycle is rejected, cycle undisturbed.
// - Four most significant read address bits are ignored.
// - Busy flag one during status write, program or erase cycle.
`timescale 1ns/1ps
`default_nettype none
`include "sflash_defines.svh"

module sflash_status_protect_read #(
    parameter int ADDR_W              = 20,
    parameter int STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES,
    parameter int PAGE_WRITE_CYCLES   = `PAGE_WRITE_CYCLES,
    parameter int REGION_WIPE_CYCLES  = `REGION_WIPE_CYCLES,
    parameter int FULL_WIPE_CYCLES    = `FULL_WIPE_CYCLES
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_arst_n,
    input  wire logic                   i_sclk,
    input  wire logic                   i_sel_n,
    input  wire logic                   i_si,
    input  wire logic                   i_wp_n,
    input  wire sflash_pkg::fill_t      i_fill,
    output logic                        o_so,
    output logic                        o_so_oe,
    output logic [7:0]                  o_status,
    output logic                        o_hw_locked,
    output logic                        o_sw_locked,
    output var sflash_pkg::array_op_t   o_array_op
);

    localparam int DEPTH = 1 << ADDR_W;

    // ****************************************************************
    // Memory array
    // ****************************************************************
    logic [7:0] mem [0:DEPTH-1];

    always_ff @(posedge i_mclk) begin
        if (i_fill.valid) begin
            mem[i_fill.addr[ADDR_W-1:0]] <= i_fill.data;
        end
    end

    // ****************************************************************
    // Link domain: frame reset and input shifting
    // ****************************************************************
    logic                    frame_rst_n;
    logic                    first_r;
    logic [2:0]              bit_idx_r;
    logic [2:0]              byte_cnt_r;
    logic [6:0]              shin_r;
    logic [7:0]              cmd_r;
    logic [23:0]             addr_r;
    logic [7:0]              sr_data_r;
    sflash_pkg::frame_kind_t fkind_r;
    sflash_pkg::frame_kind_t fkind_nxt;
    logic [2:0]              bit_now;
    logic [2:0]              byte_now;
    logic [6:0]              shin_now;
    logic [7:0]              byte_in;
    logic [7:0]              cmd_now;
    logic                    byte_done;
    logic [7:0]              stat_l;
    logic                    busy_l;

    // Deselect clears everything that must not survive a frame
    assign frame_rst_n = i_arst_n & ~i_sel_n;

    always_ff @(posedge i_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    assign bit_now   = first_r ? 3'h0 : bit_idx_r;
    assign byte_now  = first_r ? 3'h0 : byte_cnt_r;
    assign shin_now  = first_r ? 7'h00 : shin_r;
    assign byte_in   = {shin_now, i_si};
    assign byte_done = (bit_now == 3'h7);
    assign cmd_now   = (byte_now == 3'h0) ? byte_in : cmd_r;

    // Frame kind valid only if select rises right after this edge
    always_comb begin
        fkind_nxt = sflash_pkg::FR_NONE;
        if (byte_done) begin
            case (cmd_now)
                `CMD_WRITE_ARM: begin
                    if (byte_now == 3'h0) fkind_nxt = sflash_pkg::FR_ARM;
                end
                `CMD_WRITE_DISARM: begin
                    if (byte_now == 3'h0) fkind_nxt = sflash_pkg::FR_DISARM;
                end
                `CMD_FULL_WIPE: begin
                    if (byte_now == 3'h0) fkind_nxt = sflash_pkg::FR_FULL_WIPE;
                end
                `CMD_STATUS_WRITE: begin
                    if (byte_now == 3'h1) fkind_nxt = sflash_pkg::FR_STATUS_WRITE;
                end
                `CMD_REGION_WIPE: begin
                    if (byte_now == `ADDR_LAST_BYTE) fkind_nxt = sflash_pkg::FR_REGION_WIPE;
                end
                `CMD_PAGE_WRITE: begin
                    if (byte_now >= `PAGE_DATA_BYTE) fkind_nxt = sflash_pkg::FR_PAGE_WRITE;
                end
                default: begin
                    fkind_nxt = sflash_pkg::FR_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bit_idx_r  <= 3'h0;
            byte_cnt_r <= 3'h0;
            shin_r     <= 7'h00;
            fkind_r    <= sflash_pkg::FR_NONE;
        end else begin
            bit_idx_r  <= bit_now + 3'h1;
            shin_r     <= byte_in[6:0];
            fkind_r    <= fkind_nxt;
            if (byte_done && byte_now != `BYTE_CNT_MAX) begin
                byte_cnt_r <= byte_now + 3'h1;
            end else begin
                byte_cnt_r <= byte_now;
            end
        end
    end

    // Command, address and status data bytes
    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmd_r     <= 8'h00;
            addr_r    <= 24'h000000;
            sr_data_r <= 8'h00;
        end else if (byte_done) begin
            case (byte_now)
                3'h0: cmd_r <= byte_in;
                3'h1: begin
                    addr_r[23:16] <= byte_in;
                    sr_data_r     <= byte_in;
                end
                3'h2: addr_r[15:8] <= byte_in;
                3'h3: addr_r[7:0]  <= byte_in;
                default: begin
                    cmd_r <= cmd_r;
                end
            endcase
        end
    end

    // ****************************************************************
    // Link domain: read modes
    // ****************************************************************
    logic rd_arr_r;
    logic rd_stat_r;

    sync2 #(
        .WIDTH     (8),
        .RESET_VAL (8'h00)
    ) u_stat_sync (
        .i_clk    (i_sclk),
        .i_arst_n (i_arst_n),
        .i_d      (o_status),
        .o_q      (stat_l)
    );

    assign busy_l = stat_l[`SR_BUSY_BIT];

    always_ff @(posedge i_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rd_arr_r  <= 1'b0;
            rd_stat_r <= 1'b0;
        end else if (byte_done) begin
            if (byte_now == `ADDR_LAST_BYTE && cmd_r == `CMD_ARRAY_READ && !busy_l) begin
                rd_arr_r <= 1'b1;
            end
            if (byte_now == 3'h0 && byte_in == `CMD_STATUS_READ) begin
                rd_stat_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Link domain: serial output on falling edges
    // ****************************************************************
    logic [2:0]        oidx_r;
    logic [ADDR_W-1:0] ptr_r;
    logic [ADDR_W-1:0] ptr_next;
    logic              started_r;
    logic [7:0]        stat_byte_r;

    assign ptr_next = ptr_r + 1'b1;

    always_ff @(negedge i_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            o_so        <= 1'b0;
            o_so_oe     <= 1'b0;
            oidx_r      <= 3'h0;
            ptr_r       <= '0;
            started_r   <= 1'b0;
            stat_byte_r <= 8'h00;
        end else if (rd_stat_r) begin
            o_so_oe <= 1'b1;
            oidx_r  <= oidx_r + 3'h1;
            if (oidx_r == 3'h0) begin
                stat_byte_r <= stat_l;
                o_so        <= stat_l[7];
            end else begin
                o_so <= stat_byte_r[3'h7 - oidx_r];
            end
        end else if (rd_arr_r) begin
            o_so_oe   <= 1'b1;
            started_r <= 1'b1;
            oidx_r    <= oidx_r + 3'h1;
            if (!started_r) begin
                ptr_r <= addr_r[ADDR_W-1:0];
                o_so  <= mem[addr_r[ADDR_W-1:0]][7];
            end else if (oidx_r == 3'h0) begin
                ptr_r <= ptr_next;
                o_so  <= mem[ptr_next][7];
            end else begin
                o_so <= mem[ptr_r][3'h7 - oidx_r];
            end
        end else begin
            o_so_oe <= 1'b0;
        end
    end

    // ****************************************************************
    // Core domain: pin synchronisers and frame end
    // ****************************************************************
    logic [1:0] pins_s;
    logic       sel_s;
    logic       wp_s;
    logic       sel_d_r;
    logic       sel_rise;

    sync2 #(
        .WIDTH     (2),
        .RESET_VAL (2'b11)
    ) u_pin_sync (
        .i_clk    (i_mclk),
        .i_arst_n (i_arst_n),
        .i_d      ({i_sel_n, i_wp_n}),
        .o_q      (pins_s)
    );

    assign sel_s = pins_s[1];
    assign wp_s  = pins_s[0];

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel_d_r <= 1'b1;
        end else begin
            sel_d_r <= sel_s;
        end
    end

    // Frame registers are quiet here: the serial clock is stopped once select is high
    assign sel_rise = sel_s & ~sel_d_r;

    // ****************************************************************
    // Core domain: protection and self-timed cycles
    // ****************************************************************
    sflash_pkg::cyc_state_t  cyc_state_r;
    sflash_pkg::frame_kind_t cyc_kind_r;
    logic [31:0]             cyc_cnt_r;
    logic                    cyc_done;
    logic                    arm_r;
    logic                    lock_r;
    logic [2:0]              bp_r;
    logic [7:0]              pend_r;
    logic                    hw_lock;
    logic                    take;
    logic                    start;
    logic [31:0]             start_len;

    function automatic logic in_protected(input logic [2:0] bp, input logic [ADDR_W-1:0] a);
        logic [4:0] sec;
        logic [4:0] span;
        sec  = {1'b0, a[ADDR_W-1 -: 4]};
        span = 5'h01 << (bp - 3'h1);
        if (bp == 3'h0) begin
            return 1'b0;
        end else if (bp >= 3'h5) begin
            return 1'b1;
        end
        return sec >= (`SECTOR_COUNT - span);
    endfunction

    assign hw_lock = lock_r & ~wp_s;
    assign take    = sel_rise && cyc_state_r == sflash_pkg::CYC_IDLE;

    always_comb begin
        start     = 1'b0;
        start_len = 32'h0;
        case (fkind_r)
            sflash_pkg::FR_STATUS_WRITE: begin
                start     = arm_r && !hw_lock;
                start_len = 32'(STATUS_WRITE_CYCLES - 1);
            end
            sflash_pkg::FR_PAGE_WRITE: begin
                start     = arm_r && !in_protected(bp_r, addr_r[ADDR_W-1:0]);
                start_len = 32'(PAGE_WRITE_CYCLES - 1);
            end
            sflash_pkg::FR_REGION_WIPE: begin
                start     = arm_r && !in_protected(bp_r, addr_r[ADDR_W-1:0]);
                start_len = 32'(REGION_WIPE_CYCLES - 1);
            end
            sflash_pkg::FR_FULL_WIPE: begin
                start     = arm_r && bp_r == 3'h0;
                start_len = 32'(FULL_WIPE_CYCLES - 1);
            end
            default: begin
                start = 1'b0;
            end
        endcase
        start = start & take;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cyc_state_r <= sflash_pkg::CYC_IDLE;
            cyc_kind_r  <= sflash_pkg::FR_NONE;
            cyc_cnt_r   <= 32'h0;
            pend_r      <= 8'h00;
        end else begin
            case (cyc_state_r)
                sflash_pkg::CYC_IDLE: begin
                    if (start) begin
                        cyc_state_r <= sflash_pkg::CYC_RUN;
                        cyc_kind_r  <= fkind_r;
                        cyc_cnt_r   <= start_len;
                        pend_r      <= sr_data_r;
                    end
                end
                sflash_pkg::CYC_RUN: begin
                    if (cyc_cnt_r == 32'h0) begin
                        cyc_state_r <= sflash_pkg::CYC_IDLE;
                    end else begin
                        cyc_cnt_r <= cyc_cnt_r - 32'h1;
                    end
                end
                default: begin
                    cyc_state_r <= sflash_pkg::CYC_IDLE;
                end
            endcase
        end
    end

    assign cyc_done = cyc_state_r == sflash_pkg::CYC_RUN && cyc_cnt_r == 32'h0;

    // Write-arm latch
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            arm_r <= 1'b0;
        end else if (cyc_done) begin
            arm_r <= 1'b0;
        end else if (take && fkind_r == sflash_pkg::FR_ARM) begin
            arm_r <= 1'b1;
        end else if (take && fkind_r == sflash_pkg::FR_DISARM) begin
            arm_r <= 1'b0;
        end
    end

    // Protect and lock bits, loaded at the end of a status write cycle
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bp_r   <= `SR_BP_RESET;
            lock_r <= `SR_LOCK_RESET;
        end else if (cyc_done && cyc_kind_r == sflash_pkg::FR_STATUS_WRITE) begin
            bp_r   <= pend_r[`SR_BP_MSB:`SR_BP_LSB];
            lock_r <= pend_r[`SR_LOCK_BIT];
        end
    end

    // ****************************************************************
    // Core domain: outputs
    // ****************************************************************
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_status    <= 8'h00;
            o_hw_locked <= 1'b0;
            o_sw_locked <= 1'b0;
            o_array_op  <= '0;
        end else begin
            o_status    <= {lock_r, 2'b00, bp_r, arm_r,
                            cyc_state_r == sflash_pkg::CYC_RUN};
            o_hw_locked <= hw_lock;
            o_sw_locked <= bp_r != 3'h0;
            o_array_op.valid <= start && fkind_r != sflash_pkg::FR_STATUS_WRITE;
            o_array_op.kind  <= fkind_r;
            o_array_op.addr  <= addr_r;
        end
    end

endmodule

`default_nettype wire

// ===== dv/sflash_sva.sv
// Port-level assertions for the flash command block
`timescale 1ns/1ps
`default_nettype none
module sflash_sva #(
    parameter int STATUS_WRITE_CYCLES = 300
) (
    input wire logic                  i_mclk,
    input wire logic                  i_arst_n,
    input wire logic                  i_sel_n,
    input wire logic                  i_wp_n,
    input wire logic                  o_so_oe,
    input wire logic [7:0]            o_status,
    input wire logic                  o_hw_locked,
    input wire logic                  o_sw_locked,
    input wire sflash_pkg::array_op_t o_array_op
);
    localparam int BUSY_MIN = STATUS_WRITE_CYCLES - 2;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    chk_zero_bits: assert property (o_status[6:5] == 2'h0)
        else $error("status bits 6 and 5 not zero");
    chk_so_release: assert property (i_sel_n |-> !o_so_oe)
        else $error("serial out driven while deselected");
    chk_arm_first: assert property ($rose(o_status[0]) |-> $past(o_status[1]))
        else $error("busy cycle started without arm latch");
    chk_busy_len: assert property ($rose(o_status[0]) |->
        (o_status[0] throughout ##BUSY_MIN 1) ##[1:4] !o_status[0])
        else $error("busy cycle length wrong");
    chk_arm_clear: assert property ($fell(o_status[0]) |-> ##[0:1] !o_status[1])
        else $error("arm latch kept after cycle");
    chk_lock_frozen: assert property (o_hw_locked && $past(o_hw_locked) |->
        $stable(o_status[7:2]))
        else $error("status changed while hardware locked");
    chk_hw_entry: assert property ((o_status[7] && !i_wp_n) [*5] |-> o_hw_locked)
        else $error("hardware lock not entered");
    chk_hw_hold: assert property (!i_wp_n [*4] |-> !$fell(o_hw_locked))
        else $error("hardware lock left with pin low");
    chk_sw_mode: assert property ($stable(o_status[4:2]) [*2] |-> o_sw_locked == (o_status[4:2] != 3'h0))
        else $error("software lock flag wrong");
    chk_op_busy: assert property (o_array_op.valid |-> ##[0:2] o_status[0])
        else $error("array op without busy");
    cover property ($rose(o_status[0]));
    cover property ($rose(o_hw_locked));
    cover property ($fell(o_hw_locked));
    cover property (o_array_op.valid);
endmodule
bind sflash_status_protect_read sflash_sva #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) sflash_sva_inst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_sel_n(i_sel_n), .i_wp_n(i_wp_n), .o_so_oe(o_so_oe),
    .o_status(o_status), .o_hw_locked(o_hw_locked), .o_sw_locked(o_sw_locked), .o_array_op(o_array_op));
`default_nettype wire

// ===== dv/spi_master_model.sv
// Mode 0 SPI master driving the flash block's serial pins
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    output logic      o_sclk,
    output logic      o_sel_n,
    output logic      o_si,
    input  wire logic i_so,
    input  wire logic i_so_oe
);
    logic [63:0] rx;
    logic        oe_seen;
    initial begin
        o_sclk = 1'b0;
        o_sel_n = 1'b1;
        o_si = 1'b0;
    end
    // Clock stands still and data flips outside frames
    task automatic frame(input logic [63:0] tx, input int nb);
        rx = '0;
        oe_seen = 1'b0;
        o_sel_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            o_si = tx[63 - i];
            #16 o_sclk = 1'b1;
            rx = {rx[62:0], i_so_oe ? i_so : ~i_so};
            oe_seen = oe_seen | i_so_oe;
            #16 o_sclk = 1'b0;
        end
        #16 o_sel_n = 1'b1;
        o_si = ~o_si;
        #200;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_sflash_status_protect_read.sv
// Self-checking bench for the flash status write, protection and read block
`timescale 1ns/1ps
`default_nettype none
module tb_sflash_status_protect_read;
    localparam int         CYC = 300;
    logic                  i_mclk = 1'b0;
    logic                  i_arst_n = 1'b0;
    logic                  i_wp_n = 1'b1;
    sflash_pkg::fill_t     i_fill = '0;
    wire                   sclk, sel_n, si, o_so, o_so_oe, o_hw_locked, o_sw_locked;
    wire [7:0]             o_status;
    sflash_pkg::array_op_t o_array_op;
    int                    err_count = 0, n_checks = 0, cyc = 0, ops = 0;
    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (o_array_op.valid === 1'b1)
            ops <= ops + 1;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    sflash_status_protect_read #(.STATUS_WRITE_CYCLES(CYC), .PAGE_WRITE_CYCLES(CYC),
        .REGION_WIPE_CYCLES(CYC), .FULL_WIPE_CYCLES(CYC)) sflash_status_protect_read_inst (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_sclk(sclk), .i_sel_n(sel_n), .i_si(si),
        .i_wp_n(i_wp_n), .i_fill(i_fill), .o_so(o_so), .o_so_oe(o_so_oe), .o_status(o_status),
        .o_hw_locked(o_hw_locked), .o_sw_locked(o_sw_locked), .o_array_op(o_array_op));
    spi_master_model spi_master_model_inst (.o_sclk(sclk), .o_sel_n(sel_n), .o_si(si),
        .i_so(o_so), .i_so_oe(o_so_oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic frm(input logic [63:0] tx, input int nb);
        spi_master_model_inst.frame(tx, nb);
    endtask
    task automatic arm_wr(input logic [7:0] d, input int nb);
        frm({8'h06, 56'h0}, 8);
        frm({8'h01, d, 48'h0}, nb);
    endtask
    task automatic idle();
        for (int i = 0; i < 400 && o_status[0] !== 1'b0; i++)
            @(posedge i_mclk);
        tick(20);
    endtask
    task automatic t_read();
        logic [7:0] mem [3] = '{8'h5a, 8'hc3, 8'h81};
        for (int i = 0; i < 3; i++) begin
            @(posedge i_mclk);
            i_fill <= '{1'b1, (i == 2) ? 24'h0 : 24'h0ffffe + 24'(i), mem[i]};
        end
        @(posedge i_mclk);
        i_fill <= '0;
        frm({8'h03, 24'hfffffe, 32'h0}, 56);
        check(32'(spi_master_model_inst.rx[23:0]), 32'h005ac381);
        frm({8'h03, 24'hfffffe, 32'h0}, 37);
        check(32'(o_so_oe), 32'h0);
    endtask
    task automatic t_status();
        arm_wr(8'hff, 16);
        frm({8'h05, 56'h0}, 16);
        check(32'(spi_master_model_inst.rx[7:0]), 32'h03);
        frm({8'h03, 56'h0}, 56);
        check(32'(spi_master_model_inst.oe_seen), 32'h0);
        idle();
        check(32'(o_status), 32'h9c);
        frm({8'h05, 56'h0}, 16);
        check(32'(spi_master_model_inst.rx[7:0]), 32'h9c);
    endtask
    task automatic t_refuse();
        frm({8'h01, 56'h0}, 16);
        idle();
        check(32'(o_status), 32'h9c);
        arm_wr(8'h00, 20);
        idle();
        check(32'(o_status), 32'h9e);
    endtask
    task automatic t_lock();
        i_wp_n <= 1'b0;
        tick(10);
        check(32'(o_hw_locked), 32'h1);
        arm_wr(8'h00, 16);
        idle();
        check(32'(o_status), 32'h9e);
        i_wp_n <= 1'b1;
        tick(10);
        check(32'(o_hw_locked), 32'h0);
        arm_wr(8'h00, 16);
        idle();
        check({16'h0, o_status, 6'h0, o_hw_locked, o_sw_locked}, 32'h0);
        i_wp_n <= 1'b0;
        arm_wr(8'h84, 16);
        idle();
        check({16'h0, o_status, 6'h0, o_hw_locked, o_sw_locked}, 32'h8403);
    endtask
    task automatic t_wipe();
        frm({8'h06, 56'h0}, 8);
        frm({8'hd8, 24'h0f0000, 32'h0}, 32);
        idle();
        check(32'(ops), 32'h0);
        frm({8'hd8, 24'h012345, 32'h0}, 32);
        idle();
        check(32'(ops), 32'h1);
        check(32'({o_array_op.kind, o_array_op.addr}), {5'h0, sflash_pkg::FR_REGION_WIPE, 24'h012345});
    endtask
    initial begin
        tick(10);
        i_arst_n <= 1'b1;
        tick(5);
        t_read();
        t_status();
        t_refuse();
        t_lock();
        t_wipe();
        results();
    end
endmodule
`default_nettype wire
